/* dv/ltl_lane_tx_monitor.sv */
// Assertions on the lane 1 to 3 training field block
`timescale 1ns/10ps
module ltl_lane_tx_monitor
  import ltl_pkg::*;
(
  // Clock and controls
  input logic clk_i,
  input logic rst_n_i,
  input logic training_enable_ctrl_i,
  input logic training_restart_ctrl_i,
  // Outputs watched
  input logic mission_mode_o,
  input logic training_active_o,
  input logic frame_start_o,
  input ltl_block_t lane1_ctrl_block_o,
  input logic lane1_pattern_bit_o
);
  // Short names keep each property on one line
  wire en = training_enable_ctrl_i;
  wire rs = training_restart_ctrl_i;
  wire act = training_active_o;
  wire mm = mission_mode_o;
  wire fs = frame_start_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----
  // Properties
  // ----
  mode_pair_a: assert property (act != mm) else $error("mode flags");
  off_mission_a: assert property (!en |=> mm) else $error("no mission");
  on_train_a: assert property (mm && en |=> act) else $error("no training");
  mission_quiet_a: assert property (mm [*2] |-> !lane1_pattern_bit_o && !fs) else $error("mission noise");
  first_frame_a: assert property (mm && en ##1 en |=> fs) else $error("no first frame");
  restart_frame_a: assert property (act && $past(act) && !$past(rs) && rs && en ##1 en |=> fs) else $error("restart");
  block_hold_a: assert property (!fs |-> $stable(lane1_ctrl_block_o)) else $error("block moved");
  frame_pulse_a: assert property (fs |=> !fs) else $error("long marker");
endmodule

bind ltl_lane_tx ltl_lane_tx_monitor i_ltl_lane_tx_monitor (.*);

/* dv/ltl_link_partner.sv */
// Link partner model that decodes lane 1 to 3 training frames
`timescale 1ns/10ps
module ltl_link_partner (
  // Clock and frame marker
  input logic clk_i,
  input logic frame_start_i,
  // Blocks of lanes 1 to 3, then pattern bits
  input logic [38:0] line_i,
  // Decoded frame
  output logic rx_valid_o,
  output logic [38:0] rx_frame_o
);
  logic grab;
  // Blocks come with the marker, the first pattern bits a cycle later
  always @(posedge clk_i) begin
    grab <= frame_start_i;
    rx_valid_o <= grab;
    if (frame_start_i)
      rx_frame_o[38:3] <= line_i[38:3];
    if (grab)
      rx_frame_o[2:0] <= line_i[2:0];
  end
endmodule

/* dv/testbench.sv */
// Self-checking bench for the lane 1 to 3 training field block
`timescale 1ns/10ps
module testbench;
  import ltl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic en = 1'b0;
  logic rs = 1'b0;
  logic mm, ta, fs, vld;
  ltl_seed_t s [3] = '{default: 11'h000};
  ltl_field_t q [18] = '{default: 2'h0};
  ltl_block_t c [3], t [3];
  logic [2:0] p;
  logic [38:0] rx;
  logic [39:0] n, got;
  logic [39:0] notes [$];
  int num_errors = 0;
  int samples_checked = 0;
  always #5 clk_i = ~clk_i;
  ltl_lane_tx i_ltl_lane_tx (.clk_i(clk_i), .rst_n_i(rst_n_i), .training_enable_ctrl_i(en),
    .training_restart_ctrl_i(rs), .mission_mode_o(mm), .training_active_o(ta), .frame_start_o(fs),
    .lane1_pattern_seed_i(s[0]), .lane2_pattern_seed_i(s[1]), .lane3_pattern_seed_i(s[2]),
    .lane1_plus_tap_request_i(q[0]), .lane1_center_tap_request_i(q[1]), .lane1_minus_tap_request_i(q[2]),
    .lane1_plus_tap_status_i(q[3]), .lane1_center_tap_status_i(q[4]), .lane1_minus_tap_status_i(q[5]),
    .lane2_plus_tap_request_i(q[6]), .lane2_center_tap_request_i(q[7]), .lane2_minus_tap_request_i(q[8]),
    .lane2_plus_tap_status_i(q[9]), .lane2_center_tap_status_i(q[10]), .lane2_minus_tap_status_i(q[11]),
    .lane3_plus_tap_request_i(q[12]), .lane3_center_tap_request_i(q[13]), .lane3_minus_tap_request_i(q[14]),
    .lane3_plus_tap_status_i(q[15]), .lane3_center_tap_status_i(q[16]), .lane3_minus_tap_status_i(q[17]),
    .lane1_ctrl_block_o(c[0]), .lane1_stat_block_o(t[0]), .lane1_pattern_bit_o(p[0]),
    .lane2_ctrl_block_o(c[1]), .lane2_stat_block_o(t[1]), .lane2_pattern_bit_o(p[1]),
    .lane3_ctrl_block_o(c[2]), .lane3_stat_block_o(t[2]), .lane3_pattern_bit_o(p[2]));
  ltl_link_partner i_ltl_link_partner (.clk_i(clk_i), .frame_start_i(fs),
    .line_i({c[0], t[0], c[1], t[1], c[2], t[2], p}), .rx_valid_o(vld), .rx_frame_o(rx));
  task automatic check(input string w, input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Fresh lane values; 0 enables, 1 restarts, 2 waits for the periodic frame
  task automatic send(input int how);
    int k;
    n = {how != 2, 39'h0};
    @(negedge clk_i);
    for (k = 0; k < 18; k++) begin
      q[k] = $urandom;
      n[38:3] = {n[36:3], q[k]};
    end
    for (k = 0; k < 3; k++) begin
      s[k] = $urandom;
      n[k] = s[k][10];
    end
    notes.push_back(n);
    en = en | (how == 0);
    rs = (how == 1);
    @(negedge clk_i);
    rs = 1'b0;
    // Inputs stay put until the frame is back; a frame lost for 600 cycles ends the test as failed
    for (k = 0; k < 600 && notes.size() > 0; k++)
      @(negedge clk_i);
    if (notes.size() > 0) begin
      num_errors++;
      test_done();
    end
  endtask
  // Each decoded frame is matched against the oldest note
  always @(posedge clk_i) begin
    if (vld === 1'b1) begin
      got = (notes.size() > 0) ? notes.pop_front() : {1'b0, ~rx};
      check("blocks", rx[38:3], got[38:3]);
      if (got[39])
        check("seed bits", rx[2:0], got[2:0]);
    end
  end
  initial begin
    void'($urandom(2));
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    send(0);
    repeat (4) send(1);
    send(2);
    send(1);
    // Restart while training is off must leave the lanes in mission mode
    en = 1'b0;
    rs = 1'b1;
    @(negedge clk_i);
    rs = 1'b0;
    @(negedge clk_i);
    check("mode", {mm, ta}, 2'b10);
    repeat (600) @(negedge clk_i);
    send(0);
    send(1);
    test_done();
  end
endmodule

/* verilog/ltl_consts.svh */
// Constants for the lane 1 to 3 link-training transmit field block
`ifndef LTL_CONSTS_SVH
`define LTL_CONSTS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define LTL_NUM_LANES 3
`define LTL_SEED_W 11
`define LTL_FIELD_W 2
`define LTL_BLOCK_W 6

// ----------------------------------------
// Field positions inside control and status blocks
// ----------------------------------------
`define LTL_MINUS_LSB 0
`define LTL_CENTER_LSB 2
`define LTL_PLUS_LSB 4

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define LTL_BLOCK_RST 6'h00
`define LTL_SEED_RST 11'h000
`define LTL_FRAME_CYCLES 10'h224
`define LTL_FRAME_LAST 10'h223
`define LTL_CNT_W 10
`define LTL_CNT_ZERO 10'h000
`define LTL_CNT_ONE 10'h001

`endif

/* verilog/ltl_lane_tx.sv */
// Link-training transmit fields and pattern generators for lanes 1 to 3
`timescale 1ns/10ps
`include "ltl_consts.svh"

module ltl_lane_tx
  import ltl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Training control
  input wire logic training_enable_ctrl_i,
  input wire logic training_restart_ctrl_i,
  // Lane 1 controls
  input wire ltl_seed_t lane1_pattern_seed_i,
  input wire ltl_field_t lane1_plus_tap_request_i,
  input wire ltl_field_t lane1_center_tap_request_i,
  input wire ltl_field_t lane1_minus_tap_request_i,
  input wire ltl_field_t lane1_plus_tap_status_i,
  input wire ltl_field_t lane1_center_tap_status_i,
  input wire ltl_field_t lane1_minus_tap_status_i,
  // Lane 2 controls
  input wire ltl_seed_t lane2_pattern_seed_i,
  input wire ltl_field_t lane2_plus_tap_request_i,
  input wire ltl_field_t lane2_center_tap_request_i,
  input wire ltl_field_t lane2_minus_tap_request_i,
  input wire ltl_field_t lane2_plus_tap_status_i,
  input wire ltl_field_t lane2_center_tap_status_i,
  input wire ltl_field_t lane2_minus_tap_status_i,
  // Lane 3 controls
  input wire ltl_seed_t lane3_pattern_seed_i,
  input wire ltl_field_t lane3_plus_tap_request_i,
  input wire ltl_field_t lane3_center_tap_request_i,
  input wire ltl_field_t lane3_minus_tap_request_i,
  input wire ltl_field_t lane3_plus_tap_status_i,
  input wire ltl_field_t lane3_center_tap_status_i,
  input wire ltl_field_t lane3_minus_tap_status_i,
  // Sequence status
  output logic mission_mode_o,
  output logic training_active_o,
  output logic frame_start_o,
  // Lane 1 frame content
  output ltl_block_t lane1_ctrl_block_o,
  output ltl_block_t lane1_stat_block_o,
  output logic lane1_pattern_bit_o,
  // Lane 2 frame content
  output ltl_block_t lane2_ctrl_block_o,
  output ltl_block_t lane2_stat_block_o,
  output logic lane2_pattern_bit_o,
  // Lane 3 frame content
  output ltl_block_t lane3_ctrl_block_o,
  output ltl_block_t lane3_stat_block_o,
  output logic lane3_pattern_bit_o
);

  // ----------------------------------------
  // Sequence control
  // ----------------------------------------
  // State, frame counter and the registered flags
  ltl_state_t state_reg;
  ltl_state_t state_next;
  logic [`LTL_CNT_W-1:0] cnt_reg;
  logic [`LTL_CNT_W-1:0] cnt_next;
  logic mission_reg;
  logic active_reg;
  logic frame_start_reg;
  logic frame_wrap;
  logic load_seeds;
  logic run_pattern;
  logic enter_train;
  logic latch_fields;

  // Restart acts only from the train state, disable overrides restart
  // A restart held high keeps toggling between restart and train, so no
  // full frame leaves the block until it is released
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LTL_MISSION: begin
        if (training_enable_ctrl_i) begin
          state_next = LTL_RESTART;
        end
      end
      LTL_RESTART: begin
        state_next = LTL_TRAIN;
      end
      LTL_TRAIN: begin
        if (training_restart_ctrl_i) begin
          state_next = LTL_RESTART;
        end
      end
      // The spare code cannot be reached; recover through mission mode
      default: begin
        state_next = LTL_MISSION;
      end
    endcase
    if (!training_enable_ctrl_i) begin
      state_next = LTL_MISSION;
    end
  end

  // Frame timing and derived strobes
  assign frame_wrap = (cnt_reg == `LTL_FRAME_LAST);
  assign load_seeds = (state_reg == LTL_RESTART);
  assign run_pattern = (state_reg == LTL_TRAIN);
  // Fields move only when the next cycle trains, so every block change comes with a frame marker
  assign enter_train = (state_next == LTL_TRAIN);
  // New field values are taken only at a frame boundary so a frame never carries a mix
  assign latch_fields = (load_seeds | (run_pattern & frame_wrap)) & enter_train;
  // The counter is cleared outside training so each restart begins a full frame
  assign cnt_next = (!run_pattern || frame_wrap) ? `LTL_CNT_ZERO : cnt_reg + `LTL_CNT_ONE;

  // Sequence registers
  // Reset is synchronous and lands in mission mode with no frame marker
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= LTL_MISSION;
      cnt_reg <= `LTL_CNT_ZERO;
      mission_reg <= 1'b1;
      active_reg <= 1'b0;
      frame_start_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      // Flags follow the next state so they change on the same edge as the state
      mission_reg <= (state_next == LTL_MISSION);
      active_reg <= (state_next != LTL_MISSION);
      frame_start_reg <= latch_fields;
    end
  end

  assign mission_mode_o = mission_reg;
  assign training_active_o = active_reg;
  assign frame_start_o = frame_start_reg;

  // ----------------------------------------
  // Per-lane gathering of the input ports
  // ----------------------------------------
  // Index 0 holds lane 1, index 2 holds lane 3
  ltl_seed_t seed_arr [`LTL_NUM_LANES];
  ltl_block_t ctrl_arr [`LTL_NUM_LANES];
  ltl_block_t stat_arr [`LTL_NUM_LANES];
  ltl_block_t ctrl_reg [`LTL_NUM_LANES];
  ltl_block_t stat_reg [`LTL_NUM_LANES];
  logic pattern_arr [`LTL_NUM_LANES];

  // Plain ports feed the lanes directly, as in the build without a register interface
  assign seed_arr[0] = lane1_pattern_seed_i;
  assign seed_arr[1] = lane2_pattern_seed_i;
  assign seed_arr[2] = lane3_pattern_seed_i;

  // Control block: plus, center, minus from high to low
  assign ctrl_arr[0] = {lane1_plus_tap_request_i, lane1_center_tap_request_i, lane1_minus_tap_request_i};
  assign ctrl_arr[1] = {lane2_plus_tap_request_i, lane2_center_tap_request_i, lane2_minus_tap_request_i};
  assign ctrl_arr[2] = {lane3_plus_tap_request_i, lane3_center_tap_request_i, lane3_minus_tap_request_i};

  // Status block uses the same layout
  assign stat_arr[0] = {lane1_plus_tap_status_i, lane1_center_tap_status_i, lane1_minus_tap_status_i};
  assign stat_arr[1] = {lane2_plus_tap_status_i, lane2_center_tap_status_i, lane2_minus_tap_status_i};
  assign stat_arr[2] = {lane3_plus_tap_status_i, lane3_center_tap_status_i, lane3_minus_tap_status_i};

  // ----------------------------------------
  // Per-lane frame content
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `LTL_NUM_LANES; g = g + 1) begin : g_lane
      // Blocks keep their last value in mission mode, where no frame is sent
      // Fields are sampled once per frame; the controller keeps them steady meanwhile
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          ctrl_reg[g] <= `LTL_BLOCK_RST;
          stat_reg[g] <= `LTL_BLOCK_RST;
        end else if (latch_fields) begin
          ctrl_reg[g] <= ctrl_arr[g];
          stat_reg[g] <= stat_arr[g];
        end
      end

      // Each lane loads its own seed at every training start
      // The generator's state output is left open; only its bit leaves the block
      ltl_pattern_gen u_pattern (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(load_seeds),
        .run_i(run_pattern),
        .seed_i(seed_arr[g]),
        .pattern_bit_o(pattern_arr[g]),
        .state_o()
      );
    end
  endgenerate

  // ----------------------------------------
  // Output mapping
  // ----------------------------------------
  // Control blocks of lanes 1 to 3
  assign lane1_ctrl_block_o = ctrl_reg[0];
  assign lane2_ctrl_block_o = ctrl_reg[1];
  assign lane3_ctrl_block_o = ctrl_reg[2];

  // Status blocks, same field layout
  assign lane1_stat_block_o = stat_reg[0];
  assign lane2_stat_block_o = stat_reg[1];
  assign lane3_stat_block_o = stat_reg[2];

  // Pattern bits, already registered inside each generator
  assign lane1_pattern_bit_o = pattern_arr[0];
  assign lane2_pattern_bit_o = pattern_arr[1];
  assign lane3_pattern_bit_o = pattern_arr[2];

endmodule

/* verilog/ltl_pattern_gen.sv */
// Per-lane 11-bit training pattern generator
`timescale 1ns/10ps
`include "ltl_consts.svh"

module ltl_pattern_gen
  import ltl_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic load_i,
  input wire logic run_i,
  input wire ltl_seed_t seed_i,
  // Pattern
  output logic pattern_bit_o,
  output ltl_seed_t state_o
);

  ltl_seed_t lfsr_reg;
  ltl_seed_t lfsr_next;
  logic pattern_reg;
  logic feedback;

  // Polynomial x^11 + x^9 + 1; an all-zero seed locks the generator at zero
  assign feedback = lfsr_reg[10] ^ lfsr_reg[8];
  assign lfsr_next = load_i ? seed_i : (run_i ? {lfsr_reg[9:0], feedback} : lfsr_reg);

  // Shift register; load wins over run so a restart always starts from the seed
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lfsr_reg <= `LTL_SEED_RST;
      pattern_reg <= 1'b0;
    end else begin
      lfsr_reg <= lfsr_next;
      pattern_reg <= run_i & ~load_i & lfsr_reg[10];
    end
  end

  assign pattern_bit_o = pattern_reg;
  assign state_o = lfsr_reg;

endmodule

/* verilog/ltl_pkg.sv */
// Types shared by the link-training transmit field block
package ltl_pkg;

  // ----------------------------------------
  // Data types
  // ----------------------------------------
  typedef logic [10:0] ltl_seed_t;
  typedef logic [1:0] ltl_field_t;
  typedef logic [5:0] ltl_block_t;

  // ----------------------------------------
  // Training sequence states
  // ----------------------------------------
  typedef enum logic [1:0] {
    LTL_MISSION,
    LTL_RESTART,
    LTL_TRAIN
  } ltl_state_t;

endpackage
